// ==== bench/mss_inverter_model.sv ====
// Inverter stage model: counts run cycles and records the stages it is driven through
`timescale 1ns/1ps
`default_nettype none
module mss_inverter_model (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       arst_n,
   // Drive from the sequencer
   input  wire logic       runIn,
   input  wire logic [3:0] stageIn,
   // Bench side
   input  wire logic       clearIn,
   output int              runCount,
   output logic [15:0]     seenMask
);
   // Only cycles with the drive enabled count, so idle stage values are ignored
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         runCount <= 0;
         seenMask <= '0;
      end else if (clearIn) begin
         runCount <= 0;
         seenMask <= '0;
      end else if (runIn) begin
         runCount          <= runCount + 1;
         seenMask[stageIn] <= 1'b1;
      end
   end
endmodule : mss_inverter_model
`default_nettype wire

// ==== bench/mss_multi_step_speed_sequencer_tb.sv ====
// Self-checking bench of the stage sequencer
`timescale 1ns/1ps
`default_nettype none
`include "mss_defines.svh"
module mss_multi_step_speed_sequencer_tb;
   localparam logic [1:0] OK  = `MSS_RESP_OKAY;
   localparam logic [1:0] ERR = `MSS_RESP_SLVERR;
   logic        clock   = 1'b0;
   logic        arst_n  = 1'b0;
   logic        clr     = 1'b0;
   logic [11:0] awAddr  = '0;
   logic [11:0] arAddr  = '0;
   logic [31:0] wData   = '0;
   logic        awValid = 1'b0;
   logic        wValid  = 1'b0;
   logic        bReady  = 1'b0;
   logic        arValid = 1'b0;
   logic        rReady  = 1'b0;
   logic        awReady, wReady, bValid, arReady, rValid, rev, run;
   logic [1:0]  bResp, rResp;
   logic [31:0] rData;
   logic [15:0] freq, seen;
   logic [3:0]  stg;
   int          runCount;
   int          fails = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   always #5 clock = ~clock;
   // Short tick keeps the minute-mode stage within a few thousand cycles
   mss_multi_step_speed_sequencer #(.TICK_CYCLES(4)) uut (
      .clock(clock), .arst_n(arst_n),
      .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
      .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
      .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
      .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
      .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
      .s_axi_rvalid(rValid), .s_axi_rready(rReady), .freqOut_r(freq),
      .reverseOut_r(rev), .runOut_r(run), .stageOut_r(stg));
   mss_inverter_model model (
      .clock(clock), .arst_n(arst_n), .runIn(run), .stageIn(stg),
      .clearIn(clr), .runCount(runCount), .seenMask(seen));
   task test_done();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : test_done
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fails = fails + 1;
         test_done();
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task chkr(input int g, input int lo, input int hi);
      samples_checked++;
      if (g < lo || g > hi) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
      end
   endtask : chkr
   function automatic logic [31:0] pk(logic [15:0] f, logic r, logic u, logic [3:0] s);
      return {f, 6'h00, r, u, 4'h0, s};
   endfunction : pk
   // Ready is sampled mid-cycle, where it has settled, and acted on at the next edge
   task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
      logic ah, wh, bh;
      logic [1:0] r;
      @(posedge clock);
      awAddr  <= a;
      wData   <= d;
      awValid <= 1'b1;
      wValid  <= 1'b1;
      bReady  <= 1'b1;
      bh = 1'b0;
      while (!bh) begin
         @(negedge clock);
         ah = awValid && awReady;
         wh = wValid && wReady;
         bh = bValid;
         r  = bResp;
         @(posedge clock);
         if (ah) awValid <= 1'b0;
         if (wh) wValid <= 1'b0;
      end
      bReady <= 1'b0;
      chk({30'h0, r}, {30'h0, e});
   endtask : wr
   task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
           input logic [1:0] er);
      logic ah, rh;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge clock);
      arAddr  <= a;
      arValid <= 1'b1;
      rReady  <= 1'b1;
      rh = 1'b0;
      while (!rh) begin
         @(negedge clock);
         ah = arValid && arReady;
         rh = rValid;
         d  = rData;
         r  = rResp;
         @(posedge clock);
         if (ah) arValid <= 1'b0;
      end
      rReady <= 1'b0;
      chk(d & m, e);
      chk({30'h0, r}, {30'h0, er});
   endtask : rd
   task cmd(input int b);
      wr(`MSS_OFF_CTRL, 32'h0000_0001 << b, OK);
   endtask : cmd
   task waitf(input logic [3:0] s, input logic r, input int lim);
      int n;
      logic ok;
      n  = 0;
      ok = 1'b0;
      while (!ok && n < lim) begin
         @(negedge clock);
         ok = (run === r) && (!r || stg === s);
         n++;
      end
      chk({31'h0, ok}, 32'h0000_0001);
   endtask : waitf
   task halt();
      cmd(`MSS_CTRL_STOP);
      waitf(4'h0, 1'b0, 30);
   endtask : halt
   task cfg(input logic [31:0] em, rs, mem, un, t0, t2);
      wr(`MSS_OFF_ENDMODE, em, OK);
      wr(`MSS_OFF_RESTART, rs, OK);
      wr(`MSS_OFF_PWRMEM, mem, OK);
      wr(`MSS_OFF_UNIT, un, OK);
      wr(`MSS_OFF_TIME0, t0, OK);
      wr(`MSS_OFF_TIME0 + 12'h008, t2, OK);
      @(posedge clock);
      clr <= 1'b1;
      @(posedge clock);
      clr <= 1'b0;
   endtask : cfg
   task t_regs();
      rd(`MSS_OFF_DIR, 32'hFFFF_FFFF, 32'h0000_0000, OK);
      rd(`MSS_OFF_ENDMODE, 32'hFFFF_FFFF, 32'h0000_0000, OK);
      rd(`MSS_OFF_RESTART, 32'hFFFF_FFFF, 32'h0000_0000, OK);
      rd(`MSS_OFF_PWRMEM, 32'hFFFF_FFFF, 32'h0000_0000, OK);
      rd(`MSS_OFF_UNIT, 32'hFFFF_FFFF, 32'h0000_0000, OK);
      wr(`MSS_OFF_DIR, 32'h0000_20C6, OK);
      rd(`MSS_OFF_DIR, 32'hFFFF_FFFF, 32'h0000_20C6, OK);
      wr(`MSS_OFF_TIME0, 32'h0000_FDE8, OK);
      wr(`MSS_OFF_TIME0, 32'h0000_FDE9, OK);
      rd(`MSS_OFF_TIME0, 32'hFFFF_FFFF, 32'h0000_FDE8, OK);
      wr(12'h0C0, 32'h0000_0001, ERR);
      rd(12'h0C0, 32'hFFFF_FFFF, 32'h0000_0000, ERR);
   endtask : t_regs
   task t_once();
      wr(`MSS_OFF_DIR, 32'h0000_0004, OK);
      cfg(0, 0, 0, 0, 2, 2);
      cmd(`MSS_CTRL_RUN);
      waitf(4'h0, 1'b1, 20);
      chk(pk(freq, rev, run, stg), pk(16'h1234, 1'b0, 1'b1, 4'h0));
      waitf(4'h2, 1'b1, 40);
      chk(pk(freq, rev, run, stg), pk(16'h0102, 1'b1, 1'b1, 4'h2));
      waitf(4'h0, 1'b0, 40);
      chk({16'h0, seen}, 32'h0000_0005);
      repeat (20) @(negedge clock);
      chk({31'h0, run}, 32'h0000_0000);
   endtask : t_once
   task t_modes();
      cfg(1, 0, 0, 0, 2, 2);
      cmd(`MSS_CTRL_RUN);
      repeat (60) @(negedge clock);
      chk(pk(freq, rev, run, stg), pk(16'h0102, 1'b1, 1'b1, 4'h2));
      halt();
      cfg(2, 0, 0, 0, 2, 2);
      cmd(`MSS_CTRL_RUN);
      waitf(4'h2, 1'b1, 40);
      waitf(4'h0, 1'b1, 40);
      waitf(4'h2, 1'b1, 40);
      halt();
   endtask : t_modes
   task t_resume();
      cfg(0, 1, 0, 0, 2, 10);
      cmd(`MSS_CTRL_RUN);
      waitf(4'h2, 1'b1, 40);
      repeat (20) @(negedge clock);
      cmd(`MSS_CTRL_FAULT);
      waitf(4'h0, 1'b0, 20);
      cmd(`MSS_CTRL_RUN);
      waitf(4'h2, 1'b1, 10);
      waitf(4'h0, 1'b0, 60);
      chkr(runCount, 44, 58);
      cfg(0, 0, 0, 0, 2, 10);
      cmd(`MSS_CTRL_RUN);
      waitf(4'h2, 1'b1, 40);
      halt();
      cmd(`MSS_CTRL_RUN);
      waitf(4'h0, 1'b1, 10);
      halt();
   endtask : t_resume
   task t_unit();
      cfg(0, 0, 0, 1, 1, 0);
      cmd(`MSS_CTRL_RUN);
      repeat (200) @(negedge clock);
      chk(pk(freq, rev, run, stg), pk(16'h1234, 1'b0, 1'b1, 4'h0));
      halt();
   endtask : t_unit
   task t_power();
      cfg(0, 0, 0, 0, 2, 10);
      cmd(`MSS_CTRL_RUN);
      waitf(4'h2, 1'b1, 40);
      cmd(`MSS_CTRL_PWRUP);
      rd(`MSS_OFF_STATUS, 32'h0000_00F0, 32'h0000_0000, OK);
      halt();
      wr(`MSS_OFF_PWRMEM, 32'h0000_0001, OK);
      cmd(`MSS_CTRL_RUN);
      waitf(4'h2, 1'b1, 40);
      cmd(`MSS_CTRL_PWRUP);
      rd(`MSS_OFF_STATUS, 32'h0000_00F0, 32'h0000_0020, OK);
      halt();
      cmd(`MSS_CTRL_RUN);
      waitf(4'h2, 1'b1, 40);
      halt();
      cmd(`MSS_CTRL_PWRUP);
      cmd(`MSS_CTRL_RUN);
      waitf(4'h0, 1'b1, 10);
      halt();
      wr(`MSS_OFF_RESTART, 32'h0000_0001, OK);
      cmd(`MSS_CTRL_RUN);
      waitf(4'h2, 1'b1, 40);
      halt();
      cmd(`MSS_CTRL_PWRUP);
      cmd(`MSS_CTRL_RUN);
      waitf(4'h2, 1'b1, 10);
      halt();
   endtask : t_power
   initial begin
      repeat (12) @(posedge clock);
      arst_n <= 1'b1;
      wr(`MSS_OFF_MAINFREQ, 32'h0000_1234, OK);
      for (int n = 0; n < 16; n++) begin
         wr(`MSS_OFF_SPEED0 + 12'(4 * n), 32'h0000_0100 + n, OK);
      end
      t_regs();
      t_once();
      t_modes();
      t_resume();
      t_unit();
      t_power();
      test_done();
   end
endmodule : mss_multi_step_speed_sequencer_tb
`default_nettype wire

// ==== hdl/mss_defines.svh ====
// Register offsets, field positions, reset values and timing counts of the stage sequencer
`ifndef MSS_DEFINES_SVH
`define MSS_DEFINES_SVH
`define MSS_OFF_DIR       12'h000
`define MSS_OFF_ENDMODE   12'h004
`define MSS_OFF_RESTART   12'h008
`define MSS_OFF_PWRMEM    12'h00C
`define MSS_OFF_UNIT      12'h010
`define MSS_OFF_CTRL      12'h014
`define MSS_OFF_STATUS    12'h018
`define MSS_OFF_MAINFREQ  12'h01C
`define MSS_OFF_TIME0     12'h040
`define MSS_OFF_SPEED0    12'h080
`define MSS_RST_DIR       16'h0000
`define MSS_RST_MODE      16'h0000
`define MSS_RST_TIME      16'h0000
`define MSS_RST_SPEED     16'h0000
`define MSS_TIME_MAX      16'hFDE8
`define MSS_TICK_NS       100000000
`define MSS_CLK_NS        10
`define MSS_TICK_CYCLES   (`MSS_TICK_NS / `MSS_CLK_NS)
`define MSS_TICKS_PER_MIN 600
`define MSS_CTRL_RUN      0
`define MSS_CTRL_STOP     1
`define MSS_CTRL_FAULT    2
`define MSS_CTRL_PWRUP    3
`define MSS_RESP_OKAY     2'b00
`define MSS_RESP_SLVERR   2'b10
`endif

// ==== hdl/mss_multi_step_speed_sequencer.sv ====
// Multi-step speed sequencer with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "mss_defines.svh"
module mss_multi_step_speed_sequencer
   import mss_pkg::*;
#(
   parameter int TICK_CYCLES = `MSS_TICK_CYCLES
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        arst_n,
   // AXI4-Lite write
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Inverter output stage
   output logic [15:0]      freqOut_r,
   output logic             reverseOut_r,
   output logic             runOut_r,
   output logic [3:0]       stageOut_r
);
   logic [15:0] stageDirectionWord_r;
   logic [1:0]  cycleEndMode_r, restartResumeMode_r;
   logic        powerLossMemory_r, stageTimeUnit_r;
   logic [15:0] mainFrequencySetting_r;
   logic [15:0] stageTime_r  [16];
   logic [15:0] stageSpeed_r [16];
   mss_state_t  state_r;
   logic [3:0]  stage_r;
   logic [15:0] elapsed_r;
   logic [31:0] tickCnt_r;
   logic [9:0]  minCnt_r;
   logic        ranAtOutage_r;
   logic        cmdRun, cmdStop, cmdFault, cmdPwrUp;

   // Write channel: address and data accepted in either order
   logic        awHeld_r, wHeld_r;
   logic [11:0] awAddr_r;
   logic [31:0] wData_r;
   logic [3:0]  wStrb_r;
   logic        doWrite;
   assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
   assign s_axi_wready  = !wHeld_r && !s_axi_bvalid;
   assign doWrite       = awHeld_r && wHeld_r && !s_axi_bvalid;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         awHeld_r <= 1'b0;
         wHeld_r  <= 1'b0;
         awAddr_r <= 12'h000;
         wData_r  <= 32'h0000_0000;
         wStrb_r  <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `MSS_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld_r <= 1'b0;
            wHeld_r  <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awAddr_r < 12'h0C0) ? `MSS_RESP_OKAY : `MSS_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Low half-word only; upper lanes are ignored as no register is wider than 16 bits
   logic [15:0] wMerge;
   logic [15:0] wOld;
   always_comb begin
      unique case (awAddr_r)
         `MSS_OFF_DIR:      wOld = stageDirectionWord_r;
         `MSS_OFF_MAINFREQ: wOld = mainFrequencySetting_r;
         default:           wOld = 16'h0000;
      endcase
      if (awAddr_r[11:6] == 6'h01)
         wOld = stageTime_r[awAddr_r[5:2]];
      if (awAddr_r[11:6] == 6'h02)
         wOld = stageSpeed_r[awAddr_r[5:2]];
      wMerge[7:0]  = wStrb_r[0] ? wData_r[7:0]  : wOld[7:0];
      wMerge[15:8] = wStrb_r[1] ? wData_r[15:8] : wOld[15:8];
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         stageDirectionWord_r   <= `MSS_RST_DIR;
         cycleEndMode_r         <= 2'b00;
         restartResumeMode_r    <= 2'b00;
         powerLossMemory_r      <= 1'b0;
         stageTimeUnit_r        <= 1'b0;
         mainFrequencySetting_r <= `MSS_RST_SPEED;
      end else if (doWrite && wStrb_r[0]) begin
         unique case (awAddr_r)
            `MSS_OFF_DIR:      stageDirectionWord_r <= wMerge;
            `MSS_OFF_ENDMODE:  if (wData_r[15:0] <= 16'h0002) cycleEndMode_r <= wData_r[1:0];
            `MSS_OFF_RESTART:  if (wData_r[15:0] <= 16'h0001) restartResumeMode_r <= wData_r[1:0];
            `MSS_OFF_PWRMEM:   powerLossMemory_r <= wData_r[0];
            `MSS_OFF_UNIT:     stageTimeUnit_r <= wData_r[0];
            `MSS_OFF_MAINFREQ: mainFrequencySetting_r <= wMerge;
            default: ;
         endcase
      end
   end

   // Stage time and preset speed tables
   for (genvar g = 0; g < 16; g++) begin : g_stage
      always_ff @(posedge clock or negedge arst_n) begin
         if (!arst_n) begin
            stageTime_r[g]  <= `MSS_RST_TIME;
            stageSpeed_r[g] <= `MSS_RST_SPEED;
         end else if (doWrite && awAddr_r[5:2] == 4'(g)) begin
            if (awAddr_r[11:6] == 6'h01 && wMerge <= `MSS_TIME_MAX)
               stageTime_r[g] <= wMerge;
            if (awAddr_r[11:6] == 6'h02)
               stageSpeed_r[g] <= wMerge;
         end
      end
   end

   // Control strobes: self-clearing command bits
   assign cmdRun   = doWrite && awAddr_r == `MSS_OFF_CTRL && wData_r[`MSS_CTRL_RUN];
   assign cmdStop  = doWrite && awAddr_r == `MSS_OFF_CTRL && wData_r[`MSS_CTRL_STOP];
   assign cmdFault = doWrite && awAddr_r == `MSS_OFF_CTRL && wData_r[`MSS_CTRL_FAULT];
   assign cmdPwrUp = doWrite && awAddr_r == `MSS_OFF_CTRL && wData_r[`MSS_CTRL_PWRUP];

   // Read channel
   logic [15:0] rdVal;
   logic        rdHit;
   always_comb begin
      rdHit = 1'b1;
      unique case (s_axi_araddr)
         `MSS_OFF_DIR:      rdVal = stageDirectionWord_r;
         `MSS_OFF_ENDMODE:  rdVal = {14'h0000, cycleEndMode_r};
         `MSS_OFF_RESTART:  rdVal = {14'h0000, restartResumeMode_r};
         `MSS_OFF_PWRMEM:   rdVal = {15'h0000, powerLossMemory_r};
         `MSS_OFF_UNIT:     rdVal = {15'h0000, stageTimeUnit_r};
         `MSS_OFF_CTRL:     rdVal = 16'h0000;
         `MSS_OFF_STATUS:   rdVal = {8'h00, stage_r, 1'b0, ranAtOutage_r, state_r};
         `MSS_OFF_MAINFREQ: rdVal = mainFrequencySetting_r;
         default: begin
            rdVal = 16'h0000;
            rdHit = 1'b0;
         end
      endcase
      if (s_axi_araddr[11:6] == 6'h01) begin
         rdVal = stageTime_r[s_axi_araddr[5:2]];
         rdHit = 1'b1;
      end
      if (s_axi_araddr[11:6] == 6'h02) begin
         rdVal = stageSpeed_r[s_axi_araddr[5:2]];
         rdHit = 1'b1;
      end
   end
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `MSS_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {16'h0000, rdVal};
         s_axi_rresp  <= rdHit ? `MSS_RESP_OKAY : `MSS_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Time base: 0.1 s ticks, stretched 600-fold in minute mode
   logic unitTick, stageDone, lastStage;
   logic [3:0] nextStage;
   assign unitTick = (tickCnt_r == 32'(TICK_CYCLES - 1))
                   && (!stageTimeUnit_r || minCnt_r == 10'(`MSS_TICKS_PER_MIN - 1));
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         tickCnt_r <= 32'h0000_0000;
         minCnt_r  <= 10'h000;
      end else if (state_r != MssRun || stageDone) begin
         tickCnt_r <= 32'h0000_0000;
         minCnt_r  <= 10'h000;
      end else if (tickCnt_r == 32'(TICK_CYCLES - 1)) begin
         tickCnt_r <= 32'h0000_0000;
         minCnt_r  <= (minCnt_r == 10'(`MSS_TICKS_PER_MIN - 1) || !stageTimeUnit_r)
                    ? 10'h000 : minCnt_r + 10'h001;
      end else begin
         tickCnt_r <= tickCnt_r + 32'h0000_0001;
      end
   end

   // Next stage with nonzero time above the current one
   always_comb begin
      nextStage = stage_r;
      lastStage = 1'b1;
      for (int i = 15; i >= 0; i--) begin
         if (4'(i) > stage_r && stageTime_r[i] != 16'h0000) begin
            nextStage = 4'(i);
            lastStage = 1'b0;
         end
      end
   end
   assign stageDone = (state_r == MssRun) && (elapsed_r >= stageTime_r[stage_r]);

   // First nonzero stage of the sequence
   logic [3:0] firstStage;
   always_comb begin
      firstStage = 4'h0;
      for (int i = 15; i >= 0; i--) begin
         if (stageTime_r[i] != 16'h0000)
            firstStage = 4'(i);
      end
   end

   // Sequencer; stop and fault share one path so they are treated alike
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_r       <= MssIdle;
         stage_r       <= 4'h0;
         elapsed_r     <= 16'h0000;
         ranAtOutage_r <= 1'b0;
      end else if (cmdPwrUp) begin
         // Outage: register contents model the retained store
         state_r <= MssIdle;
         if (!powerLossMemory_r) begin
            stage_r       <= 4'h0;
            elapsed_r     <= 16'h0000;
            ranAtOutage_r <= 1'b0;
         end else begin
            ranAtOutage_r <= (state_r != MssIdle);
            if (state_r == MssIdle && restartResumeMode_r == 2'b00) begin
               stage_r   <= 4'h0;
               elapsed_r <= 16'h0000;
            end
         end
      end else if (cmdStop || cmdFault) begin
         state_r       <= MssIdle;
         ranAtOutage_r <= 1'b0;
         if (restartResumeMode_r == 2'b00 || state_r == MssHold) begin
            stage_r   <= 4'h0;
            elapsed_r <= 16'h0000;
         end // else elapsed kept
      end else if (cmdRun && state_r == MssIdle) begin
         state_r       <= MssRun;
         ranAtOutage_r <= 1'b0;
         if (stage_r == 4'h0 && elapsed_r == 16'h0000 && !ranAtOutage_r)
            stage_r <= firstStage;
         // Resumes saved stage with remaining time
      end else if (state_r == MssRun) begin
         if (stageDone) begin
            elapsed_r <= 16'h0000;
            if (!lastStage) begin
               stage_r <= nextStage;
            end else begin
               unique case (cycleEndMode_r)
                  2'b01: state_r <= MssHold;
                  2'b10: stage_r <= firstStage;
                  default: begin
                     state_r <= MssIdle;
                     stage_r <= 4'h0;
                  end
               endcase
            end
         end else if (unitTick) begin
            elapsed_r <= elapsed_r + 16'h0001;
         end
      end
   end

   // Outputs to the inverter stage
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         freqOut_r    <= 16'h0000;
         reverseOut_r <= 1'b0;
         runOut_r     <= 1'b0;
         stageOut_r   <= 4'h0;
      end else begin
         freqOut_r    <= (stage_r == 4'h0) ? mainFrequencySetting_r : stageSpeed_r[stage_r];
         reverseOut_r <= stageDirectionWord_r[stage_r];
         runOut_r     <= (state_r != MssIdle);
         stageOut_r   <= stage_r;
      end
   end

   // Assertions
   stop_mode0_a: assert property (@(posedge clock) disable iff (!arst_n)
      stageDone && lastStage && cycleEndMode_r == 2'b00 && !cmdStop && !cmdFault && !cmdPwrUp
      |=> state_r == MssIdle ##1 !runOut_r)
      else $error("sequence did not stop after one cycle");
   hold_mode1_a: assert property (@(posedge clock) disable iff (!arst_n)
      stageDone && lastStage && cycleEndMode_r == 2'b01 && !cmdStop && !cmdFault && !cmdPwrUp
      |=> state_r == MssHold && stage_r == $past(stage_r))
      else $error("final stage not held");
   loop_mode2_a: assert property (@(posedge clock) disable iff (!arst_n)
      stageDone && lastStage && cycleEndMode_r == 2'b10 && !cmdStop && !cmdFault && !cmdPwrUp
      |=> state_r == MssRun && elapsed_r == 16'h0000)
      else $error("cycle did not repeat");
   restart_first_a: assert property (@(posedge clock) disable iff (!arst_n)
      (cmdStop || cmdFault) && !cmdPwrUp && restartResumeMode_r == 2'b00
      |=> stage_r == 4'h0 && elapsed_r == 16'h0000)
      else $error("stop did not rewind");
   resume_keep_a: assert property (@(posedge clock) disable iff (!arst_n)
      (cmdStop || cmdFault) && !cmdPwrUp && restartResumeMode_r == 2'b01 && state_r == MssRun
      |=> stage_r == $past(stage_r) && elapsed_r == $past(elapsed_r))
      else $error("stage progress lost on stop");
   pwr_nomem_a: assert property (@(posedge clock) disable iff (!arst_n)
      cmdPwrUp && !powerLossMemory_r |=> stage_r == 4'h0 && state_r == MssIdle)
      else $error("power-up without memory did not rewind");
   pwr_running_a: assert property (@(posedge clock) disable iff (!arst_n)
      cmdPwrUp && powerLossMemory_r && state_r == MssRun |=> stage_r == $past(stage_r))
      else $error("running stage lost at power-up");
   pwr_stopped_a: assert property (@(posedge clock) disable iff (!arst_n)
      cmdPwrUp && powerLossMemory_r && state_r == MssIdle && restartResumeMode_r == 2'b00
      |=> stage_r == 4'h0)
      else $error("stopped power-up did not rewind");
   dir_bit_a: assert property (@(posedge clock) disable iff (!arst_n)
      reverseOut_r == $past(stageDirectionWord_r[stage_r]))
      else $error("direction does not follow word");
   freq_sel_a: assert property (@(posedge clock) disable iff (!arst_n)
      $past(stage_r) == 4'h0 |-> freqOut_r == $past(mainFrequencySetting_r))
      else $error("stage 0 not on main frequency");
endmodule : mss_multi_step_speed_sequencer
`default_nettype wire

// ==== hdl/mss_pkg.sv ====
// Types of the stage sequencer
`default_nettype none
package mss_pkg;
   typedef enum logic [1:0] {MssIdle, MssRun, MssHold} mss_state_t;
endpackage : mss_pkg
`default_nettype wire
